// ===== hw/piolc_ctrl.sv
// piolc_ctrl: parallel i/o line controller, 32 lines, set/clear command ports
// assumes commands are one-cycle strobes with a bit mask; pins via in/out/oe
`timescale 1ns/1ps
module piolc_ctrl
    import piolc_pkg::*;
#(
    parameter piolc_pkg::piolc_word_t OWNERSHIP_RST = piolc_pkg::OWNERSHIP_STATUS_RST,
    parameter piolc_pkg::piolc_word_t PERIPH_MUXED = piolc_pkg::PERIPH_MUX_RST
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // clock gating from the power manager
    input wire logic clock_enable_cmd_i,
    input wire logic clock_disable_cmd_i,
    output logic clock_on_o,
    // pull-up
    input wire logic [31:0] pullup_enable_cmd_i,
    input wire logic [31:0] pullup_disable_cmd_i,
    output logic [31:0] pullup_status_o,
    // ownership and peripheral select
    input wire logic [31:0] ownership_enable_cmd_i,
    input wire logic [31:0] ownership_disable_cmd_i,
    output logic [31:0] ownership_status_o,
    input wire logic [31:0] select_a_cmd_i,
    input wire logic [31:0] select_b_cmd_i,
    output logic [31:0] periph_select_status_o,
    // output control
    input wire logic [31:0] output_enable_cmd_i,
    input wire logic [31:0] output_disable_cmd_i,
    output logic [31:0] output_enable_status_o,
    input wire logic [31:0] set_output_cmd_i,
    input wire logic [31:0] clear_output_cmd_i,
    input wire logic output_data_wr_i,
    input wire logic [31:0] output_data_wdata_i,
    output logic [31:0] output_data_word_o,
    input wire logic [31:0] write_mask_enable_cmd_i,
    input wire logic [31:0] write_mask_disable_cmd_i,
    output logic [31:0] write_mask_status_o,
    input wire logic [31:0] open_drain_enable_cmd_i,
    input wire logic [31:0] open_drain_disable_cmd_i,
    output logic [31:0] open_drain_status_o,
    // input side
    output logic [31:0] pin_level_readback_o,
    input wire logic [31:0] filter_enable_cmd_i,
    input wire logic [31:0] filter_disable_cmd_i,
    output logic [31:0] filter_status_o,
    input wire logic [31:0] change_irq_enable_cmd_i,
    input wire logic [31:0] change_irq_disable_cmd_i,
    output logic [31:0] change_irq_mask_o,
    input wire logic change_irq_status_rd_i,
    output logic [31:0] change_irq_status_o,
    output logic change_irq_o,
    // pads
    input wire logic [31:0] pad_in_i,
    output logic [31:0] pad_out_o,
    output logic [31:0] pad_oe_o,
    output logic [31:0] pad_pullup_en_o,
    // peripherals
    input wire logic [31:0] periph_a_out_i,
    input wire logic [31:0] periph_a_oe_i,
    input wire logic [31:0] periph_b_out_i,
    input wire logic [31:0] periph_b_oe_i,
    output logic [31:0] periph_in_o
);
    import piolc_pkg::*;

    function automatic piolc_word_t set_clr(input piolc_word_t cur, input piolc_word_t s,
                                            input piolc_word_t c);
        set_clr = (cur | s) & ~c;
    endfunction

    logic clock_on_ff;
    piolc_word_t pullup_ff, own_ff, sel_ff, oe_ff, od_ff, mask_ff, mdrv_ff;
    piolc_word_t filt_ff, imask_ff, istat_ff, rb_ff, last_ff;
    piolc_word_t pad_out_ff, pad_oe_ff, periph_in_ff, pu_pad_ff;
    logic irq_ff;
    piolc_word_t pin_sync, pin_filt;
    piolc_word_t nxt_od, nxt_istat, nxt_own, nxt_pullup, nxt_imask, change;
    piolc_word_t sel_out, sel_oe, drv_level, drv_en;

    piolc_sync #(.WIDTH(LINE_COUNT)) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(pad_in_i),
        .sync_o(pin_sync)
    );

    piolc_filter #(.WIDTH(LINE_COUNT)) u_filt (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .en_i(clock_on_ff),
        .filter_on_i(filt_ff),
        .level_i(pin_sync),
        .level_o(pin_filt)
    );

    assign nxt_od = set_clr((od_ff & ~(mask_ff & {32{output_data_wr_i}}))
                            | (output_data_wdata_i & mask_ff & {32{output_data_wr_i}}),
                            set_output_cmd_i, clear_output_cmd_i);
    // non-muxed lines stay with the controller
    assign nxt_own = set_clr(own_ff, ownership_enable_cmd_i, ownership_disable_cmd_i)
                     | ~PERIPH_MUXED;
    assign change = (pin_filt ^ last_ff) & {32{clock_on_ff}};
    // read clears, a new change still wins
    assign nxt_istat = (change_irq_status_rd_i ? '0 : istat_ff) | change;
    assign nxt_pullup = set_clr(pullup_ff, pullup_disable_cmd_i, pullup_enable_cmd_i);
    assign nxt_imask = set_clr(imask_ff, change_irq_enable_cmd_i, change_irq_disable_cmd_i);

    // selected peripheral drives when owned by it
    assign sel_out = set_clr(periph_a_out_i & ~sel_ff, periph_b_out_i & sel_ff, '0);
    assign sel_oe = set_clr(periph_a_oe_i & ~sel_ff, periph_b_oe_i & sel_ff, '0);
    assign drv_level = (own_ff & od_ff) | (~own_ff & sel_out);
    assign drv_en = (own_ff & oe_ff) | (~own_ff & sel_oe);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            clock_on_ff <= CLOCK_ON_RST;
        else
            clock_on_ff <= (clock_on_ff | clock_enable_cmd_i) & ~clock_disable_cmd_i;
    end

    // pull-ups all on; pad enable is its own flop
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pullup_ff <= PULLUP_STATUS_RST;
            pu_pad_ff <= ~PULLUP_STATUS_RST;
        end
        else
        begin
            pullup_ff <= nxt_pullup;
            pu_pad_ff <= ~nxt_pullup;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            own_ff <= OWNERSHIP_RST | ~PERIPH_MUXED;
        else
            own_ff <= nxt_own;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            sel_ff <= SELECT_STATUS_RST;
        else
            sel_ff <= set_clr(sel_ff, select_b_cmd_i, select_a_cmd_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            oe_ff <= OUTPUT_ENABLE_RST;
        else
            oe_ff <= set_clr(oe_ff, output_enable_cmd_i, output_disable_cmd_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            od_ff <= OUTPUT_DATA_RST;
        else
            od_ff <= nxt_od;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            mask_ff <= WRITE_MASK_RST;
        else
            mask_ff <= set_clr(mask_ff, write_mask_enable_cmd_i, write_mask_disable_cmd_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            mdrv_ff <= OPEN_DRAIN_RST;
        else
            mdrv_ff <= set_clr(mdrv_ff, open_drain_enable_cmd_i, open_drain_disable_cmd_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            filt_ff <= FILTER_STATUS_RST;
        else
            filt_ff <= set_clr(filt_ff, filter_enable_cmd_i, filter_disable_cmd_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            imask_ff <= IRQ_MASK_RST;
        else
            imask_ff <= nxt_imask;
    end

    // pending changes, cleared by a read
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            istat_ff <= IRQ_STATUS_RST;
        else
            istat_ff <= nxt_istat;
    end

    // readback follows pins only while clocked
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rb_ff <= '0;
            last_ff <= '0;
        end
        else if (clock_on_ff)
        begin
            rb_ff <= pin_filt;
            last_ff <= pin_filt;
        end
    end

    // masked OR, same mask as the one reported
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(nxt_istat & nxt_imask);
    end

    // open drain: drive only when low
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pad_out_ff <= '0;
            pad_oe_ff <= '0;
        end
        else
        begin
            pad_out_ff <= drv_level;
            pad_oe_ff <= drv_en & ~(mdrv_ff & drv_level);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            periph_in_ff <= '0;
        else
            periph_in_ff <= pin_sync;
    end

    assign clock_on_o = clock_on_ff;
    assign pullup_status_o = pullup_ff;
    assign ownership_status_o = own_ff;
    assign periph_select_status_o = sel_ff;
    assign output_enable_status_o = oe_ff;
    assign output_data_word_o = od_ff;
    assign write_mask_status_o = mask_ff;
    assign open_drain_status_o = mdrv_ff;
    assign pin_level_readback_o = rb_ff;
    assign filter_status_o = filt_ff;
    assign change_irq_mask_o = imask_ff;
    assign change_irq_status_o = istat_ff;
    assign change_irq_o = irq_ff;
    assign pad_out_o = pad_out_ff;
    assign pad_oe_o = pad_oe_ff;
    // pull-up on while status bit is zero
    assign pad_pullup_en_o = pu_pad_ff;
    assign periph_in_o = periph_in_ff;
endmodule // piolc_ctrl

// ===== hw/piolc_filter.sv
// piolc_filter: per-line glitch filter on the synchronised level
// assumes clock enable gating by the caller; holds state while disabled
`timescale 1ns/1ps
module piolc_filter #(
    parameter int unsigned WIDTH = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // control
    input wire logic en_i,
    input wire logic [WIDTH-1:0] filter_on_i,
    // data
    input wire logic [WIDTH-1:0] level_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] held_ff;

    // one sample of delay: synchronised pulses last a whole cycle and must pass;
    // anything shorter never gets through the synchroniser on a single clock
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            held_ff <= '0;
        end
        else if (en_i)
        begin
            held_ff <= level_i;
        end
    end

    generate
        for (genvar g = 0; g < WIDTH; g++)
        begin : g_sel
            // per-line bypass when the filter is off
            assign level_o[g] = filter_on_i[g] ? held_ff[g] : level_i[g];
        end
    endgenerate
endmodule // piolc_filter

// ===== hw/piolc_pkg.sv
// piolc_pkg: constants shared by the parallel i/o line controller
// assumes a single 40 MHz clock and a synchronous active-high reset
package piolc_pkg;
    localparam int unsigned LINE_COUNT = 32;
    typedef logic [LINE_COUNT-1:0] piolc_word_t;
    // reset values of the status words
    localparam piolc_word_t PULLUP_STATUS_RST = 32'h0000_0000;
    localparam piolc_word_t OWNERSHIP_STATUS_RST = 32'hffff_ffff;
    localparam piolc_word_t PERIPH_MUX_RST = 32'hffff_ffff;
    localparam piolc_word_t SELECT_STATUS_RST = 32'h0000_0000;
    localparam piolc_word_t OUTPUT_ENABLE_RST = 32'h0000_0000;
    localparam piolc_word_t OUTPUT_DATA_RST = 32'h0000_0000;
    localparam piolc_word_t WRITE_MASK_RST = 32'h0000_0000;
    localparam piolc_word_t OPEN_DRAIN_RST = 32'h0000_0000;
    localparam piolc_word_t FILTER_STATUS_RST = 32'h0000_0000;
    localparam piolc_word_t IRQ_MASK_RST = 32'h0000_0000;
    localparam piolc_word_t IRQ_STATUS_RST = 32'h0000_0000;
    localparam logic CLOCK_ON_RST = 1'b0;
    // synchroniser depth in master clock cycles
    localparam int unsigned SYNC_STAGES = 2;
endpackage

// ===== hw/piolc_sync.sv
// piolc_sync: two-flop synchroniser for a word of pin levels
// assumes pins are asynchronous to clk_i; stage one feeds only stage two
`timescale 1ns/1ps
module piolc_sync #(
    parameter int unsigned WIDTH = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end
        else
        begin
            stage1_ff <= async_i;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_o = stage2_ff;
endmodule // piolc_sync

// ===== testbench/parallel_io_line_controller_tb_top.sv
// parallel_io_line_controller_tb_top: directed scenarios for piolc_ctrl
// assumes the pad model closes the loop from pad outputs to pad inputs
`timescale 1ns/1ps
module parallel_io_line_controller_tb_top;
    import piolc_pkg::*;
    logic clk_i, sys_rst_i, clock_enable_cmd_i, clock_disable_cmd_i, output_data_wr_i;
    logic change_irq_status_rd_i, clock_on_o, change_irq_o;
    logic [31:0] pullup_enable_cmd_i, pullup_disable_cmd_i, ownership_enable_cmd_i;
    logic [31:0] ownership_disable_cmd_i, select_a_cmd_i, select_b_cmd_i, output_enable_cmd_i;
    logic [31:0] output_disable_cmd_i, set_output_cmd_i, clear_output_cmd_i, output_data_wdata_i;
    logic [31:0] write_mask_enable_cmd_i, write_mask_disable_cmd_i, open_drain_enable_cmd_i;
    logic [31:0] open_drain_disable_cmd_i, filter_enable_cmd_i, filter_disable_cmd_i;
    logic [31:0] change_irq_enable_cmd_i, change_irq_disable_cmd_i, ext_en_i, ext_val_i;
    logic [31:0] pullup_status_o, ownership_status_o, periph_select_status_o, pad_in_i;
    logic [31:0] output_enable_status_o, output_data_word_o, write_mask_status_o, pad_out_o;
    logic [31:0] open_drain_status_o, pin_level_readback_o, filter_status_o, change_irq_mask_o;
    logic [31:0] change_irq_status_o, pad_oe_o, pad_pullup_en_o, periph_a_out_i, periph_a_oe_i;
    logic [31:0] periph_b_out_i, periph_b_oe_i, periph_in_o;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    // line 16 boots peripheral-owned; line 31 has no peripheral behind it
    localparam piolc_word_t OWN_RESET = 32'hfffe_ffff;
    localparam piolc_word_t MUXED_LINES = 32'h7fff_ffff;
    piolc_ctrl #(.OWNERSHIP_RST(OWN_RESET), .PERIPH_MUXED(MUXED_LINES)) uut (.*);
    piolc_pad_model u_pads (.*);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic clr;
        {clock_enable_cmd_i, clock_disable_cmd_i, output_data_wr_i, change_irq_status_rd_i} = '0;
        {pullup_enable_cmd_i, pullup_disable_cmd_i, ownership_enable_cmd_i, select_a_cmd_i,
            ownership_disable_cmd_i, select_b_cmd_i, output_enable_cmd_i, output_disable_cmd_i,
            set_output_cmd_i, clear_output_cmd_i, write_mask_enable_cmd_i, filter_enable_cmd_i,
            write_mask_disable_cmd_i, open_drain_enable_cmd_i, open_drain_disable_cmd_i,
            filter_disable_cmd_i, change_irq_enable_cmd_i, change_irq_disable_cmd_i} = '0;
    endtask
    // commands are one-cycle strobes: let n edges take them (one by default), then drop all
    task automatic step(input int n = 1);
        repeat (n) @(negedge clk_i);
        clr();
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic t_reset;
        chk("clock_on", 32'h0, {31'h0, clock_on_o});
        chk("pullup", PULLUP_STATUS_RST, pullup_status_o);
        chk("owner", OWN_RESET, ownership_status_o);
        chk("pad_oe", ~OWN_RESET, pad_oe_o);
        chk("select", 32'h0, periph_select_status_o);
        chk("mask", 32'h0, write_mask_status_o);
        chk("drain", 32'h0, open_drain_status_o);
    endtask
    task automatic t_cmds;
        pullup_disable_cmd_i = 32'h0000_000f;
        output_enable_cmd_i = 32'hf000_0000;
        filter_enable_cmd_i = 32'h0000_00f0;
        step();
        chk("pullup", 32'h0000_000f, pullup_status_o);
        chk("pad_pullup", 32'hffff_fff0, pad_pullup_en_o);
        chk("oe", 32'hf000_0000, output_enable_status_o);
        chk("filter", 32'h0000_00f0, filter_status_o);
        pullup_enable_cmd_i = 32'h0000_0003;
        output_disable_cmd_i = 32'h3000_0000;
        filter_disable_cmd_i = 32'h0000_0030;
        step();
        chk("pullup", 32'h0000_000c, pullup_status_o);
        chk("pad_pullup", 32'hffff_fff3, pad_pullup_en_o);
        chk("oe", 32'hc000_0000, output_enable_status_o);
        chk("filter", 32'h0000_00c0, filter_status_o);
    endtask
    task automatic t_filter;
        clock_enable_cmd_i = 1'b1;
        step(4);
        // one-cycle pulse on filtered line 6 and plain line 12
        ext_val_i = 32'h0000_1040;
        step();
        ext_val_i = 32'h0;
        step(2);
        chk("readback", 32'h0000_1000, pin_level_readback_o & 32'h0000_1040);
        chk("periph_in", 32'h0000_1040, periph_in_o & 32'h0000_1040);
        step();
        chk("readback", 32'h0000_0040, pin_level_readback_o & 32'h0000_1040);
        chk("istat", 32'h0000_1040, change_irq_status_o & 32'h0000_1040);
        step(4);
    endtask
    task automatic t_irq;
        clock_enable_cmd_i = 1'b1;
        change_irq_enable_cmd_i = 32'h0000_0100;
        step();
        chk("mask", 32'h0000_0100, change_irq_mask_o);
        step(6);
        change_irq_status_rd_i = 1'b1;
        step();
        chk("istat", 32'h0, change_irq_status_o);
        ext_val_i = 32'h0000_0300;
        step(6);
        chk("readback", 32'h0000_0300, pin_level_readback_o & 32'h0000_ffff);
        chk("istat", 32'h0000_0300, change_irq_status_o);
        chk("irq", 32'h1, {31'h0, change_irq_o});
        change_irq_status_rd_i = 1'b1;
        step(2);
        chk("istat", 32'h0, change_irq_status_o);
        chk("irq", 32'h0, {31'h0, change_irq_o});
        clock_disable_cmd_i = 1'b1;
        step();
        ext_val_i = 32'h0;
        step(6);
        chk("readback", 32'h0000_0300, pin_level_readback_o & 32'h0000_ffff);
    endtask
    task automatic t_mux;
        select_b_cmd_i = 32'h0000_0010;
        // hand line 4 over with a select and an ownership release
        ownership_disable_cmd_i = 32'h8000_0010;
        step(2);
        chk("owner", 32'hfffe_ffef, ownership_status_o);
        chk("pad_oe", 32'h0000_0010, pad_oe_o & 32'h0000_0010);
        chk("pad_out", 32'h0, pad_out_o & 32'h0000_0010);
        select_a_cmd_i = 32'h0000_0010;
        step(2);
        chk("pad_out", 32'h0000_0010, pad_out_o & 32'h0000_0010);
        open_drain_enable_cmd_i = 32'h0000_0010;
        step(2);
        chk("pad_oe", 32'h0, pad_oe_o & 32'h0000_0010);
    endtask
    task automatic t_write;
        write_mask_enable_cmd_i = 32'h0000_00ff;
        step();
        write_mask_disable_cmd_i = 32'h0000_00f0;
        step();
        output_data_wr_i = 1'b1;
        output_data_wdata_i = 32'hffff_ffff;
        step();
        chk("data", 32'h0000_000f, output_data_word_o);
        set_output_cmd_i = 32'h0000_0110;
        clear_output_cmd_i = 32'h0000_0001;
        step();
        chk("data", 32'h0000_011e, output_data_word_o);
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // run should take well under the 2000-cycle limit
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial
    begin
        sys_rst_i = 1'b1;
        ext_en_i = 32'hffff_ffff;
        ext_val_i = 32'h0;
        output_data_wdata_i = 32'h0;
        clr();
        step(4);
        sys_rst_i = 1'b0;
        step();
        t_reset();
        t_cmds();
        t_filter();
        t_irq();
        t_mux();
        t_write();
        tally_and_finish();
    end
endmodule // parallel_io_line_controller_tb_top

// ===== testbench/piolc_ctrl_assertions.sv
// piolc_ctrl_assertions: port-level checks bound into piolc_ctrl
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
module piolc_ctrl_assertions
    import piolc_pkg::*;
#(
    parameter piolc_word_t PERIPH_MUXED = PERIPH_MUX_RST
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // watched ports
    input wire logic clock_enable_cmd_i,
    input wire logic clock_on_o,
    input wire logic [31:0] pullup_enable_cmd_i,
    input wire logic [31:0] pullup_status_o,
    input wire logic [31:0] ownership_disable_cmd_i,
    input wire logic [31:0] ownership_status_o,
    input wire logic [31:0] select_a_cmd_i,
    input wire logic [31:0] select_b_cmd_i,
    input wire logic [31:0] periph_select_status_o,
    input wire logic [31:0] write_mask_status_o,
    input wire logic [31:0] open_drain_status_o,
    input wire logic [31:0] pin_level_readback_o,
    input wire logic [31:0] change_irq_mask_o,
    input wire logic [31:0] change_irq_status_o,
    input wire logic change_irq_o,
    input wire logic [31:0] pad_out_o,
    input wire logic [31:0] pad_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_pu;
        (pullup_enable_cmd_i != 0) |=> (pullup_status_o & $past(pullup_enable_cmd_i)) == 0;
    endproperty
    a_pu: assert property (p_pu) else $error("pull-up stays off");
    property p_selb;
        (select_b_cmd_i & ~select_a_cmd_i) != 0 |=> (periph_select_status_o
            & $past(select_b_cmd_i & ~select_a_cmd_i)) == $past(select_b_cmd_i & ~select_a_cmd_i);
    endproperty
    a_selb: assert property (p_selb) else $error("select b not set");
    property p_own;
        (ownership_disable_cmd_i != 0) |=>
            (ownership_status_o & $past(ownership_disable_cmd_i) & PERIPH_MUXED) == 0;
    endproperty
    a_own: assert property (p_own) else $error("ownership not released");
    property p_nomux;
        (ownership_status_o | PERIPH_MUXED) == 32'hffff_ffff;
    endproperty
    a_nomux: assert property (p_nomux) else $error("plain line not owned");
    property p_od;
        (pad_oe_o & pad_out_o & $past(open_drain_status_o)) == 0;
    endproperty
    a_od: assert property (p_od) else $error("open drain drives high");
    property p_frz;
        (!clock_on_o && !clock_enable_cmd_i) |=> $stable(pin_level_readback_o);
    endproperty
    a_frz: assert property (p_frz) else $error("readback moved while gated");
    property p_irq;
        change_irq_o == |(change_irq_status_o & change_irq_mask_o);
    endproperty
    a_irq: assert property (p_irq) else $error("irq not masked status");
    property p_rst;
        $fell(sys_rst_i) |-> !clock_on_o && write_mask_status_o == 0
            && pullup_status_o == 0 && periph_select_status_o == 0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule // piolc_ctrl_assertions
bind piolc_ctrl piolc_ctrl_assertions #(.PERIPH_MUXED(PERIPH_MUXED)) u_chk (.*);

// ===== testbench/piolc_pad_model.sv
// piolc_pad_model: pins, external drivers and peripherals a/b
// assumes the bench sets ext_en_i/ext_val_i; undriven lines follow the pull-up
`timescale 1ns/1ps
module piolc_pad_model (
    // from the controller
    input wire logic [31:0] pad_out_o,
    input wire logic [31:0] pad_oe_o,
    input wire logic [31:0] pad_pullup_en_o,
    // external drivers
    input wire logic [31:0] ext_en_i,
    input wire logic [31:0] ext_val_i,
    // to the controller
    output logic [31:0] pad_in_i,
    output logic [31:0] periph_a_out_i,
    output logic [31:0] periph_a_oe_i,
    output logic [31:0] periph_b_out_i,
    output logic [31:0] periph_b_oe_i
);
    // controller wins a contention so expectations stay simple
    assign pad_in_i = (pad_oe_o & pad_out_o) | (~pad_oe_o & ext_en_i & ext_val_i)
        | (~pad_oe_o & ~ext_en_i & pad_pullup_en_o);
    assign periph_a_out_i = 32'h0000_ffff;
    assign periph_b_out_i = 32'hffff_0000;
    assign periph_a_oe_i = 32'hffff_ffff;
    assign periph_b_oe_i = 32'hffff_ffff;
endmodule // piolc_pad_model
